// >>> tig_params.svh
// Register map, setup menu codes, reset values and timing figures of the trigger sequencer
`ifndef TIG_PARAMS_SVH
`define TIG_PARAMS_SVH

`define ADDR_CFG    8'h00
`define ADDR_MENU   8'h04
`define ADDR_TIMES  8'h08
`define ADDR_LEVELS 8'h0c
`define ADDR_PULSE  8'h10
`define ADDR_SPOT   8'h14
`define ADDR_STATUS 8'h18

`define MENU_EXIT    8'h00
`define MENU_RST2    8'h01
`define MENU_RST4    8'h02
`define MENU_SPOT    8'h10
`define MENU_SPOTFIX 8'h11
`define MENU_BILEVEL 8'h20
`define MENU_PEDAL   8'h30
`define MENU_IGN     8'h40
`define MENU_FACTORY 8'h99

`define DEF_PRE   8'h01
`define DEF_UP    8'h05
`define DEF_DOWN  8'h00
`define DEF_POST  8'h0a
`define DEF_WELD  9'h005
`define DEF_START 8'h1e
`define DEF_CRAT  8'h1e
`define DEF_BG    8'h1e
`define DEF_DUTY  8'h32
`define DEF_FREQ  12'h001
`define DEF_IGN   3'h3
`define DEF_THR   8'h32
`define DEF_SPOT  8'h00

`define CLK_MHZ      10
`define TICK_US      10000
`define HF_MAX_MS    3000
`define DEBOUNCE_MS  20
`define TENTH_MS     100
`define SECOND_MS    1000

`endif

// >>> tig_pkg.sv
// Types shared by the trigger sequencer
`default_nettype none
package tig_pkg;
	typedef enum logic [1:0] {P_STICK, P_LIFT, P_HF} proc_t;
	typedef enum logic [1:0] {T_2S, T_4S, T_SPOT, T_BILEVEL} trig_mode_t;
	typedef enum logic [3:0] {S_IDLE, S_PRE, S_IGN, S_START, S_UP, S_WELD, S_DOWN, S_RAMPUP, S_POST} seq_t;

	typedef struct packed {
		seq_t        st;
		proc_t       proc;
		trig_mode_t  tmode;
		logic        pulse;
		logic        rst2, rst4, spot_en, spot_fix, bl_en, pedal;
		logic [2:0]  ign;
		logic [7:0]  pre, up, down, post;
		logic [8:0]  weld;
		logic [7:0]  start_p, crat_p, bg_p, duty, spot_t, thr;
		logic [11:0] freq;
		logic [31:0] tick_cnt;
		logic        tick;
		logic        tdb;
		logic [3:0]  dcnt;
		logic [15:0] hcnt;
		logic        hfired;
		logic [15:0] tmr;
		logic        fin, ret, lvl_b;
		logic [9:0]  sp, tgt, diff;
		logic [31:0] acc, tot;
		logic        gas, out_en, hf;
		logic [31:0] rdata;
	} state_t;
endpackage
`default_nettype wire

// >>> tig_trigger_sequencer.sv
// Torch trigger sequencer: gas, output enable, HF and current setpoint
`include "tig_params.svh"
`default_nettype none

// What this block does
// - Spot mode selectable only with option 10
// - Spot uses HF start, no slopes
// - Spot time zero follows the trigger
// - Postflow only in gas modes
// - During weld only current, pulse values writable
// - 2-step press: preflow, arc, upslope
// - 2-step release in upslope stops arc
// - 2-step release: downslope, off, postflow
// - 2-step press in downslope holds present current
// - 2-step restart ramps back to weld
// - 4-step press: preflow, arc, start current
// - 4-step released trigger skips start phase
// - 4-step release upslopes; press aborts
// - 4-step hold downslopes, release ends
// - Default 4-step, restart off
// - 4-step restart release ramps back up
// - Quick press downslopes then off
// - Second quick press stops at once
// - Two-level only with option 20
// - Quick press toggles primary and secondary
// - Two-level hold holds crater, no restart
// - Setup menu codes committed by write
// - HF at most three seconds, then abort
module tig_trigger_sequencer #(
	parameter int TICK_CYCLES = `TICK_US * `CLK_MHZ
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        trig,
	input  wire logic        arc_ok,
	output logic             gas_valve,
	output logic             out_en,
	output logic             hf_on,
	output logic      [9:0]  setpoint
);

	localparam int TENTH_TICKS = (`TENTH_MS * 1000) / `TICK_US;
	localparam int SEC_TICKS   = (`SECOND_MS * 1000) / `TICK_US;
	localparam int HF_TICKS    = (`HF_MAX_MS * 1000) / `TICK_US;
	localparam int DEB_TICKS   = (`DEBOUNCE_MS * 1000 + `TICK_US - 1) / `TICK_US;

	if (TICK_CYCLES < 2 || TICK_CYCLES > 1000000 || DEB_TICKS > 15) begin : g_bad_param
		$error("tig_trigger_sequencer: tick length out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic tig_pkg::state_t factory(input tig_pkg::state_t s);
		tig_pkg::state_t r;
		r         = s;
		r.tmode   = tig_pkg::T_4S;
		r.rst2    = 1'b0;
		r.rst4    = 1'b0;
		r.spot_en = 1'b0;
		r.spot_fix = 1'b0;
		r.bl_en   = 1'b0;
		r.pedal   = 1'b0;
		r.ign     = `DEF_IGN;
		r.pre     = `DEF_PRE;
		r.up      = `DEF_UP;
		r.down    = `DEF_DOWN;
		r.post    = `DEF_POST;
		r.weld    = `DEF_WELD;
		r.start_p = `DEF_START;
		r.crat_p  = `DEF_CRAT;
		r.bg_p    = `DEF_BG;
		r.duty    = `DEF_DUTY;
		r.freq    = `DEF_FREQ;
		r.spot_t  = `DEF_SPOT;
		r.thr     = `DEF_THR;
		r.pulse   = 1'b0;
		return r;
	endfunction

	localparam tig_pkg::state_t RST_VAL = factory('0);

	function automatic logic [9:0] pct(input logic [8:0] a, input logic [7:0] p);
		logic [16:0] m;
		m = {8'h00, a} * {9'h000, p};
		m = m / 17'd100;
		return (m > 17'd1023) ? 10'h3ff : m[9:0];
	endfunction

	// Duration is exact: one amp step each time the accumulator passes the total
	function automatic tig_pkg::state_t ramp(input tig_pkg::state_t s, input logic [9:0] t,
		input logic [7:0] tenths);
		tig_pkg::state_t r;
		r      = s;
		r.tgt  = t;
		r.acc  = 32'h0000_0000;
		r.diff = (t > s.sp) ? t - s.sp : s.sp - t;
		r.tot  = 32'(tenths * TENTH_TICKS * TICK_CYCLES);
		return r;
	endfunction

	// Arc off, gas left running for postflow
	function automatic tig_pkg::state_t stop_arc(input tig_pkg::state_t s);
		tig_pkg::state_t r;
		r        = s;
		r.out_en = 1'b0;
		r.hf     = 1'b0;
		r.sp     = 10'h000;
		r.tgt    = 10'h000;
		r.st     = tig_pkg::S_POST;
		r.tmr    = 16'(s.post * SEC_TICKS);
		return r;
	endfunction

	tig_pkg::state_t q, n;
	logic press_ev, rel_ev, hold_ev, quick_ev, long_rel, tmr_done, ramp_done, idle, wlv;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n = q;
		n.rdata = 32'h0000_0000;
		idle = (q.st == tig_pkg::S_IDLE);
		// Given a value on every path so it never holds over as a latch
		wlv = q.lvl_b;

		// Time base
		n.tick = 1'b0;
		if (q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			n.tick_cnt = 32'h0000_0000;
			n.tick = 1'b1;
		end else begin
			n.tick_cnt = q.tick_cnt + 32'h0000_0001;
		end

		// Debounce: the raw level must differ for the whole debounce time
		if (trig != q.tdb) begin
			if (q.tick) begin
				n.dcnt = q.dcnt + 4'h1;
			end
			if (q.dcnt >= 4'(DEB_TICKS)) begin
				n.tdb = trig;
				n.dcnt = 4'h0;
			end
		end else begin
			n.dcnt = 4'h0;
		end
		press_ev = n.tdb & ~q.tdb;
		rel_ev   = ~n.tdb & q.tdb;

		// Quick or held classification
		hold_ev  = q.tdb && !q.hfired && (q.hcnt >= {8'h00, q.thr});
		quick_ev = rel_ev && !q.hfired;
		long_rel = rel_ev && q.hfired;
		if (press_ev) begin
			n.hcnt = 16'h0000;
			n.hfired = 1'b0;
		end else begin
			if (q.tdb && q.tick && q.hcnt != 16'hffff) begin
				n.hcnt = q.hcnt + 16'h0001;
			end
			if (hold_ev) begin
				n.hfired = 1'b1;
			end
		end

		// Phase timer
		tmr_done = (q.tmr == 16'h0000);
		if (q.tick && !tmr_done) begin
			n.tmr = q.tmr - 16'h0001;
		end

		// Ramp engine
		ramp_done = (q.sp == q.tgt);
		if (!ramp_done) begin
			if (q.tot == 32'h0000_0000) begin
				n.sp = q.tgt;
			end else if (q.acc + {22'h00_0000, q.diff} >= q.tot) begin
				n.acc = q.acc + {22'h00_0000, q.diff} - q.tot;
				n.sp  = (q.tgt > q.sp) ? q.sp + 10'h001 : q.sp - 10'h001;
			end else begin
				n.acc = q.acc + {22'h00_0000, q.diff};
			end
		end

		// Sequencer
		case (q.st)
			tig_pkg::S_IDLE: begin
				n.gas = 1'b0;
				n.hf  = 1'b0;
				n.lvl_b = 1'b0;
				// Stick has no gas and no trigger sequence
				n.out_en = (q.proc == tig_pkg::P_STICK);
				n.sp  = (q.proc == tig_pkg::P_STICK) ? {1'b0, q.weld} : 10'h000;
				n.tgt = n.sp;
				if (press_ev && q.proc != tig_pkg::P_STICK) begin
					n.gas = 1'b1;
					n.st  = tig_pkg::S_PRE;
					n.tmr = 16'(q.pre * TENTH_TICKS);
				end
			end
			tig_pkg::S_PRE: begin
				if (tmr_done) begin
					n.out_en = 1'b1;
					n.hf  = (q.proc == tig_pkg::P_HF) || (q.tmode == tig_pkg::T_SPOT);
					n.tmr = 16'(HF_TICKS);
					n.st  = tig_pkg::S_IGN;
				end
			end
			tig_pkg::S_IGN: begin
				if (arc_ok) begin
					n.hf = 1'b0;
					case (q.tmode)
						tig_pkg::T_2S: begin
							n.sp = pct(q.weld, q.start_p);
							n = ramp(n, {1'b0, q.weld}, q.up);
							n.st = tig_pkg::S_UP;
						end
						tig_pkg::T_SPOT: begin
							n.sp  = {1'b0, q.weld};
							n.tgt = {1'b0, q.weld};
							n.fin = q.spot_fix && (q.spot_t != 8'h00);
							n.tmr = 16'(q.spot_t * TENTH_TICKS);
							n.st  = tig_pkg::S_WELD;
						end
						default: begin
							n.sp = pct(q.weld, q.start_p);
							n.tgt = n.sp;
							if (n.tdb) begin
								n.st = tig_pkg::S_START;
							end else begin
								n = ramp(n, {1'b0, q.weld}, q.up);
								n.st = tig_pkg::S_UP;
							end
						end
					endcase
				end else if (q.hf && tmr_done) begin
					// No arc in time: whole sequence dropped
					n.hf = 1'b0;
					n.out_en = 1'b0;
					n.gas = 1'b0;
					n.st = tig_pkg::S_IDLE;
				end
			end
			tig_pkg::S_START: begin
				if (rel_ev) begin
					n = ramp(n, {1'b0, q.weld}, q.up);
					n.st = tig_pkg::S_UP;
				end
			end
			tig_pkg::S_UP: begin
				if (q.tmode == tig_pkg::T_2S && rel_ev) begin
					n = stop_arc(n);
				end else if (q.tmode != tig_pkg::T_2S && press_ev) begin
					n = stop_arc(n);
				end else if (ramp_done) begin
					n.st = tig_pkg::S_WELD;
				end
			end
			tig_pkg::S_WELD: begin
				if (q.tmode == tig_pkg::T_SPOT) begin
					if (q.fin ? tmr_done : rel_ev) begin
						n = stop_arc(n);
					end
				end else if (q.tmode == tig_pkg::T_2S) begin
					if (rel_ev) begin
						n = ramp(n, pct(q.weld, q.crat_p), q.down);
						n.fin = 1'b1;
						n.ret = 1'b0;
						n.st  = tig_pkg::S_DOWN;
					end
				end else if (q.tmode == tig_pkg::T_BILEVEL && quick_ev) begin
					wlv = ~q.lvl_b;
				end else if (hold_ev) begin
					n = ramp(n, pct(q.weld, q.crat_p), q.down);
					n.fin = 1'b0;
					n.ret = q.rst4 && (q.tmode == tig_pkg::T_4S);
					n.st  = tig_pkg::S_DOWN;
				end else if (quick_ev) begin
					n = ramp(n, pct(q.weld, q.crat_p), q.down);
					n.fin = 1'b1;
					n.ret = 1'b0;
					n.st  = tig_pkg::S_DOWN;
				end
				// Level follows live edits of the weld current
				if (n.st == tig_pkg::S_WELD && q.tmode != tig_pkg::T_SPOT) begin
					n.lvl_b = wlv;
					n.sp  = wlv ? pct(q.weld, q.bg_p) : {1'b0, q.weld};
					n.tgt = n.sp;
				end
			end
			tig_pkg::S_DOWN: begin
				if (q.tmode == tig_pkg::T_2S) begin
					if (press_ev && q.fin) begin
						if (q.rst2) begin
							n = ramp(n, {1'b0, q.weld}, q.up);
							n.st = tig_pkg::S_RAMPUP;
						end else begin
							n.fin = 1'b0;
							n.tgt = q.sp;
						end
					end else if (rel_ev && !q.fin) begin
						n = stop_arc(n);
					end else if (q.fin && ramp_done) begin
						n = stop_arc(n);
					end
				end else if (q.fin && quick_ev) begin
					n = stop_arc(n);
				end else if (q.fin && hold_ev) begin
					n.fin = 1'b0;
					n.tgt = q.sp;
					n.ret = q.rst4 && (q.tmode == tig_pkg::T_4S);
				end else if (!q.fin && long_rel) begin
					if (q.ret) begin
						n = ramp(n, {1'b0, q.weld}, q.up);
						n.st = tig_pkg::S_RAMPUP;
					end else begin
						n = stop_arc(n);
					end
				end else if (q.fin && ramp_done) begin
					n = stop_arc(n);
				end
			end
			tig_pkg::S_RAMPUP: begin
				if (q.tmode == tig_pkg::T_2S && rel_ev) begin
					n = ramp(n, pct(q.weld, q.crat_p), q.down);
					n.fin = 1'b1;
					n.st  = tig_pkg::S_DOWN;
				end else if (ramp_done) begin
					n.st = tig_pkg::S_WELD;
				end
			end
			tig_pkg::S_POST: begin
				if (tmr_done) begin
					n.gas = 1'b0;
					n.st  = tig_pkg::S_IDLE;
				end
			end
			default: begin
				n = stop_arc(n);
			end
		endcase

		////////////////////////////////////////////////////////////////////////////
		// Register port

		if (wr) begin
			case (addr)
				`ADDR_CFG: begin
					if (idle) begin
						n.proc  = tig_pkg::proc_t'((wdata[1:0] == 2'h3) ? 2'h2 : wdata[1:0]);
						n.pulse = wdata[4] && (wdata[3:2] != 2'(tig_pkg::T_BILEVEL));
						if ((wdata[3:2] == 2'(tig_pkg::T_SPOT) && q.spot_en) ||
							(wdata[3:2] == 2'(tig_pkg::T_BILEVEL) && q.bl_en) ||
							wdata[3] == 1'b0) begin
							n.tmode = tig_pkg::trig_mode_t'(wdata[3:2]);
						end
					end
				end
				`ADDR_MENU: begin
					if (idle) begin
						case (wdata[15:8])
							`MENU_RST2: n.rst2 = wdata[0];
							`MENU_RST4: n.rst4 = wdata[0];
							`MENU_SPOT: begin
								n.spot_en = wdata[0];
								if (!wdata[0] && q.tmode == tig_pkg::T_SPOT) begin
									n.tmode = tig_pkg::T_4S;
								end
							end
							`MENU_SPOTFIX: n.spot_fix = wdata[0];
							`MENU_BILEVEL: begin
								n.bl_en = wdata[0];
								if (!wdata[0] && q.tmode == tig_pkg::T_BILEVEL) begin
									n.tmode = tig_pkg::T_4S;
								end
							end
							`MENU_PEDAL: n.pedal = wdata[0];
							`MENU_IGN: begin
								if (wdata[2:0] != 3'h0 && wdata[2:0] != 3'h7) begin
									n.ign = wdata[2:0];
								end
							end
							`MENU_FACTORY: n = factory(n);
							default: n.rst2 = n.rst2;
						endcase
					end
				end
				`ADDR_TIMES: begin
					if (idle) begin
						{n.post, n.down, n.up, n.pre} = wdata;
					end
				end
				`ADDR_LEVELS: begin
					n.weld = wdata[8:0];
					if (idle) begin
						n.crat_p  = wdata[23:16];
						n.start_p = wdata[31:24];
					end
				end
				`ADDR_PULSE: begin
					if (idle || q.pulse) begin
						n.duty = wdata[7:0];
						n.freq = wdata[19:8];
						n.bg_p = wdata[31:24];
					end
				end
				`ADDR_SPOT: begin
					if (idle) begin
						n.spot_t = wdata[7:0];
						n.thr    = (wdata[15:8] == 8'h00) ? 8'h01 : wdata[15:8];
					end
				end
				default: n.rdata = 32'h0000_0000;
			endcase
		end
		if (rd) begin
			case (addr)
				`ADDR_CFG:    n.rdata = {27'h000_0000, q.pulse, q.tmode, q.proc};
				`ADDR_MENU:   n.rdata = {21'h00_0000, q.ign, 2'h0, q.pedal, q.bl_en, q.spot_fix,
					q.spot_en, q.rst4, q.rst2};
				`ADDR_TIMES:  n.rdata = {q.post, q.down, q.up, q.pre};
				`ADDR_LEVELS: n.rdata = {q.start_p, q.crat_p, 7'h00, q.weld};
				`ADDR_PULSE:  n.rdata = {q.bg_p, 4'h0, q.freq, q.duty};
				`ADDR_SPOT:   n.rdata = {16'h0000, q.thr, q.spot_t};
				`ADDR_STATUS: n.rdata = {6'h00, q.sp, 7'h00, q.tdb, q.lvl_b, q.hf, q.out_en, q.gas, q.st};
				default:      n.rdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST_VAL;
		end else begin
			q <= n;
		end
	end

	assign rdata     = q.rdata;
	assign gas_valve = q.gas;
	assign out_en    = q.out_en;
	assign hf_on     = q.hf;
	assign setpoint  = q.sp;

endmodule // tig_trigger_sequencer
`default_nettype wire

// >>> torch_model.sv
// Operator torch and arc model facing the trigger sequencer
`default_nettype none
module torch_model #(
	parameter int ARC_DLY = 5
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic press,
	input  wire logic arc_fail,
	input  wire logic out_en,
	output var logic  trig,
	output var logic  arc_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig <= 1'b0;
			arc_ok <= 1'b0;
			n <= 0;
		end else begin
			trig <= press;
			// Arc strikes a few cycles after output comes on, unless told to fail
			n <= (out_en && !arc_fail) ? n + 1 : 0;
			arc_ok <= out_en && !arc_fail && n >= ARC_DLY;
		end
	end
endmodule // torch_model
`default_nettype wire

// >>> tig_seq_monitor.sv
// Concurrent checks on the trigger sequencer ports
`default_nettype none
module tig_seq_monitor #(
	parameter int TICK_CYCLES = 100000
) (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        trig,
	input wire logic        arc_ok,
	input wire logic        gas_valve,
	input wire logic        out_en,
	input wire logic        hf_on,
	input wire logic [9:0]  setpoint
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// One tick of slack for the phase of the tick counter
	localparam int HF_LIM = 301 * TICK_CYCLES;
	logic [31:0] hf_cnt_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hf_cnt_q <= 32'h0000_0000;
		end else begin
			hf_cnt_q <= hf_on ? hf_cnt_q + 32'h0000_0001 : 32'h0000_0000;
		end
	end
	////////////////////////////////////////
	a_hf_needs_out: assert property (hf_on |-> out_en)
		else $error("ignition while output off");
	a_hf_needs_gas: assert property (hf_on |-> gas_valve)
		else $error("ignition without gas");
	a_hf_arc_off: assert property (arc_ok && hf_on |-> ##[1:4] !hf_on)
		else $error("ignition kept after arc");
	a_hf_bounded: assert property (hf_cnt_q <= HF_LIM)
		else $error("ignition too long");
	a_pre_delay: assert property ($rose(gas_valve) |-> !out_en [*8])
		else $error("output on without preflow");
	a_post_gas: assert property ($fell(out_en) && $past(gas_valve) && $past(arc_ok) |-> gas_valve)
		else $error("gas closed with arc stop");
	a_setpoint_off: assert property (!out_en |-> setpoint == 10'h000)
		else $error("setpoint while output off");
	a_rdata_slot: assert property (rdata != 32'h0000_0000 |-> $past(rd))
		else $error("read data outside slot");
	a_trig_debounce: assert property ($rose(gas_valve) |-> trig && $past(trig, 16))
		else $error("gas opened on short press");
	c_hf: cover property ($rose(hf_on));
	c_arc: cover property (arc_ok && hf_on);
	c_post: cover property ($fell(out_en) && gas_valve);
endmodule // tig_seq_monitor
`default_nettype wire

// >>> tig_trigger_sequencer_test.sv
// Self-checking bench for the trigger sequencer
`default_nettype none
module tig_trigger_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK_CYCLES = 20;
	logic        sys_clk, rst_n, wr, rd, press, arc_fail;
	logic        trig, arc_ok, gas_valve, out_en, hf_on;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [9:0]  setpoint;
	int          n_fail, checks_done;

	tig_trigger_sequencer #(.TICK_CYCLES(TICK_CYCLES)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig(trig), .arc_ok(arc_ok),
		.gas_valve(gas_valve), .out_en(out_en), .hf_on(hf_on), .setpoint(setpoint));
	torch_model u_torch (.sys_clk(sys_clk), .rst_n(rst_n), .press(press), .arc_fail(arc_fail),
		.out_en(out_en), .trig(trig), .arc_ok(arc_ok));

	////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd_reg(a, v);
		cmp(v, e);
	endtask
	// Polls the state field, two cycles a poll
	task automatic wait_st(input logic [3:0] s, input int lim);
		logic [31:0] v;
		v = 32'hffff_ffff;
		for (int i = 0; i < lim && v[3:0] !== s; i++) begin
			rd_reg(8'h18, v);
		end
		cmp(32'(v[3:0]), 32'(s));
	endtask
	task automatic pins(input logic g, input logic o, input logic h, input logic [9:0] sp);
		cmp({19'h0_0000, gas_valve, out_en, hf_on, setpoint}, {19'h0_0000, g, o, h, sp});
	endtask
	task automatic push(input logic v);
		@(posedge sys_clk);
		press <= v;
	endtask

	////////////////////////////////////////
	task automatic t_reset();
		// Reset leaves the process field at stick, trigger mode 4-step
		rd_chk(8'h00, 32'h0000_0004);
		rd_chk(8'h04, 32'h0000_0300);
		rd_chk(8'h08, 32'h0a00_0501);
		rd_chk(8'h1c, 32'h0000_0000);
	endtask
	task automatic t_menu();
		logic [31:0] codes [6];
		codes = '{32'h0000_0101, 32'h0000_0201, 32'h0000_1101, 32'h0000_3001, 32'h0000_4006, 32'h0000_4007};
		wr_reg(8'h00, 32'h0000_000a);
		rd_chk(8'h00, 32'h0000_0006);
		wr_reg(8'h04, 32'h0000_1001);
		wr_reg(8'h00, 32'h0000_000a);
		rd_chk(8'h00, 32'h0000_000a);
		wr_reg(8'h00, 32'h0000_000e);
		rd_chk(8'h00, 32'h0000_000a);
		wr_reg(8'h04, 32'h0000_2001);
		wr_reg(8'h00, 32'h0000_000e);
		rd_chk(8'h00, 32'h0000_000e);
		foreach (codes[i]) begin
			wr_reg(8'h04, codes[i]);
		end
		rd_chk(8'h04, 32'h0000_063f);
		wr_reg(8'h04, 32'h0000_2000);
		rd_chk(8'h00, 32'h0000_0006);
		wr_reg(8'h04, 32'h0000_9900);
		wr_reg(8'h04, 32'h0000_0000);
		rd_chk(8'h04, 32'h0000_0300);
	endtask
	task automatic t_two_step();
		wr_reg(8'h08, 32'h0100_0001);
		wr_reg(8'h00, 32'h0000_0002);
		push(1'b1);
		wait_st(4'h1, 100);
		pins(1'b1, 1'b0, 1'b0, 10'h000);
		wait_st(4'h5, 400);
		pins(1'b1, 1'b1, 1'b0, 10'h005);
		wr_reg(8'h08, 32'h0a00_0501);
		push(1'b0);
		wait_st(4'h8, 100);
		pins(1'b1, 1'b0, 1'b0, 10'h000);
		wait_st(4'h0, 1500);
		rd_chk(8'h08, 32'h0100_0001);
	endtask
	task automatic t_up_abort();
		wr_reg(8'h08, 32'h0100_0501);
		push(1'b1);
		wait_st(4'h4, 400);
		cmp(32'(out_en), 32'h0000_0001);
		push(1'b0);
		// Upslope lasts far longer than this poll span
		wait_st(4'h8, 60);
		pins(1'b1, 1'b0, 1'b0, 10'h000);
		wait_st(4'h0, 1500);
	endtask
	task automatic t_four_step();
		wr_reg(8'h08, 32'h0105_0501);
		wr_reg(8'h00, 32'h0000_0006);
		push(1'b1);
		wait_st(4'h3, 400);
		cmp(32'(out_en & gas_valve), 32'h0000_0001);
		push(1'b0);
		wait_st(4'h4, 60);
		wait_st(4'h5, 800);
		pins(1'b1, 1'b1, 1'b0, 10'h005);
		push(1'b1);
		// Hold is recognised only after the threshold of 50 ticks
		wait_st(4'h6, 600);
		repeat (1200) @(posedge sys_clk);
		wait_st(4'h6, 1);
		pins(1'b1, 1'b1, 1'b0, 10'h001);
		push(1'b0);
		wait_st(4'h8, 60);
		pins(1'b1, 1'b0, 1'b0, 10'h000);
		wait_st(4'h0, 1500);
	endtask
	task automatic t_stick();
		wr_reg(8'h00, 32'h0000_0004);
		repeat (10) @(posedge sys_clk);
		pins(1'b0, 1'b1, 1'b0, 10'h005);
		push(1'b1);
		repeat (300) @(posedge sys_clk);
		cmp(32'(gas_valve), 32'h0000_0000);
		push(1'b0);
		repeat (100) @(posedge sys_clk);
		wr_reg(8'h00, 32'h0000_0002);
	endtask
	task automatic t_hf_timeout();
		arc_fail <= 1'b1;
		push(1'b1);
		wait_st(4'h2, 200);
		pins(1'b1, 1'b1, 1'b1, 10'h000);
		// Ignition limit is 300 ticks of 20 cycles
		repeat (6100) @(posedge sys_clk);
		pins(1'b0, 1'b0, 1'b0, 10'h000);
		wait_st(4'h0, 1);
		push(1'b0);
		arc_fail <= 1'b0;
	endtask
	task automatic t_spot();
		// Lets the release of the previous press pass the debounce
		repeat (100) @(posedge sys_clk);
		wr_reg(8'h04, 32'h0000_1001);
		wr_reg(8'h04, 32'h0000_1101);
		wr_reg(8'h14, 32'h0000_3201);
		wr_reg(8'h00, 32'h0000_000a);
		push(1'b1);
		wait_st(4'h5, 200);
		// Upslope is still half a second, so full current at once shows no slope
		pins(1'b1, 1'b1, 1'b0, 10'h005);
		wait_st(4'h8, 150);
		pins(1'b1, 1'b0, 1'b0, 10'h000);
		push(1'b0);
		wait_st(4'h0, 1500);
		wr_reg(8'h14, 32'h0000_3200);
		push(1'b1);
		wait_st(4'h5, 200);
		repeat (400) @(posedge sys_clk);
		wait_st(4'h5, 1);
		push(1'b0);
		wait_st(4'h8, 60);
		wait_st(4'h0, 1500);
	endtask
	task automatic t_bilevel();
		wr_reg(8'h04, 32'h0000_2001);
		wr_reg(8'h08, 32'h0100_0001);
		wr_reg(8'h00, 32'h0000_000e);
		rd_chk(8'h00, 32'h0000_000e);
		push(1'b1);
		wait_st(4'h3, 200);
		push(1'b0);
		wait_st(4'h5, 100);
		pins(1'b1, 1'b1, 1'b0, 10'h005);
		// Each quick press stays far below the hold threshold
		for (int i = 0; i < 2; i++) begin
			push(1'b1);
			repeat (100) @(posedge sys_clk);
			push(1'b0);
			repeat (100) @(posedge sys_clk);
			pins(1'b1, 1'b1, 1'b0, (i == 0) ? 10'h001 : 10'h005);
		end
		push(1'b1);
		wait_st(4'h6, 600);
		repeat (10) @(posedge sys_clk);
		pins(1'b1, 1'b1, 1'b0, 10'h001);
		push(1'b0);
		wait_st(4'h8, 60);
		wait_st(4'h0, 1500);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		{rst_n, wr, rd, press, arc_fail} = 5'h00;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		n_fail = 0;
		checks_done = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_menu();
		t_two_step();
		t_up_abort();
		t_four_step();
		t_stick();
		t_hf_timeout();
		t_spot();
		t_bilevel();
		stop_test();
	end
	initial begin
		// Scenarios need about 27000 cycles, postflow and ignition limit dominate
		repeat (50000) @(posedge sys_clk);
		n_fail++;
		$display("wrong value at %0t: run timed out", $time);
		stop_test();
	end
endmodule // tig_trigger_sequencer_test

bind tig_trigger_sequencer tig_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
	.rd(rd), .rdata(rdata), .trig(trig), .arc_ok(arc_ok), .gas_valve(gas_valve), .out_en(out_en),
	.hf_on(hf_on), .setpoint(setpoint));
`default_nettype wire
